// >>> verilog/sep_pkg.sv
// Shared constants for the serial EEPROM command port and its controller
package sep_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned STORE_MS = 5;
  localparam int unsigned STORE_CYC = STORE_MS * (CLK_HZ / 1000);
  localparam int unsigned GAP_NS = 250;
  localparam int unsigned GAP_CYC = (GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned HALF_NS = 250;
  localparam int unsigned HALF_CYC = (HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned TMR_W = 18;
  // ------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------
  localparam int unsigned MEM_BYTES = 2048;
  localparam logic [4:0] HDR_X16 = 5'h0C;
  localparam logic [4:0] HDR_X8 = 5'h0D;
  localparam logic [4:0] WLEN_X16 = 5'h10;
  localparam logic [4:0] WLEN_X8 = 5'h08;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] PFX_LOCK = 2'h0;
  localparam logic [1:0] PFX_FILL = 2'h1;
  localparam logic [1:0] PFX_CLEAR = 2'h2;
  localparam logic [1:0] PFX_UNLOCK = 2'h3;
  localparam logic [15:0] ERASED = 16'hFFFF;
  // ------------------------------------------------------------
  // Controller registers and commands
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam int unsigned CTRL_WIDE_BIT = 3;
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h1;
  localparam logic [2:0] CMD_ERASE = 3'h2;
  localparam logic [2:0] CMD_UNLOCK = 3'h3;
  localparam logic [2:0] CMD_LOCK = 3'h4;
  localparam logic [2:0] CMD_CLEAR = 3'h5;
  localparam logic [2:0] CMD_FILL = 3'h6;
endpackage : sep_pkg

// >>> verilog/sep_link_if.sv
// Serial link between controller and EEPROM command port
`timescale 1ns/1ps
interface sep_link_if;
  logic cs;
  logic sk;
  logic di;
  logic dout;
  logic doe;
  logic do_line;

  // Released output line is pulled high
  assign do_line = doe ? dout : 1'b1;

  modport dev (input cs, input sk, input di, output dout, output doe);
  modport host (output cs, output sk, output di, input do_line);
endinterface : sep_link_if

// >>> verilog/sep_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module sep_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins and synchronised copies
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : sep_sync

// >>> verilog/sep_dev.sv
// EEPROM serial command port: frame decoder, read streamer, store timer
//
// Overview of operation
// - Frame: start bit, opcode, address, optional data
// - Header is 13 or 14 bits
// - Input bits sampled on serial clock rise
// - Output released except read data and status
// - Status low while busy, high when ready
// - Dummy high bit releases status on fall
// - Opcodes read, write, erase, special by prefix
// - Programming needs write guard pin high
// - Read sends dummy low then word MSB first
// - Read bits change on serial clock rise
// - Read continues with next address, wraps
// - Dummy low bit only before first word
// - Store starts on select falling edge
// - Store completes alone within five milliseconds
// - Write clears location automatically
// - Erase sets location to all ones
// - Power up locked; unlock and lock commands
// - Locked device ignores writes, reads work
// - Clear-all sets every bit to one
// - Fill-all writes word to every location
// - Width pin high selects 16-bit words
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module sep_dev #(
  parameter int unsigned STORE_CYCLES = sep_pkg::STORE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link
  sep_link_if.dev link,
  // Board straps
  input wire logic width_select_pin_i,
  input wire logic write_guard_pin_i,
  // Status
  output logic busy_o,
  output logic unlocked_o
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_HDR, S_DATA, S_READ, S_DONE, S_STAT} sep_dst_e;

  typedef struct packed {
    sep_dst_e st;
    logic sk_q;
    logic cs_q;
    logic wide;
    logic [4:0] cnt;
    logic [12:0] hdr;
    logic [15:0] dsh;
    logic [1:0] op;
    logic [1:0] pfx;
    logic [10:0] addr;
    logic [15:0] rd;
    logic [4:0] rcnt;
    logic unlocked;
    logic stat_on;
    logic rel;
    logic dout;
    logic doe;
    logic [sep_pkg::TMR_W-1:0] tmr;
    logic walk;
    logic wwide;
    logic [10:0] idx;
    logic [10:0] last;
    logic [15:0] fdata;
  } sep_dev_s;

  sep_dev_s s;
  sep_dev_s next_s;
  logic [7:0] mem [sep_pkg::MEM_BYTES];
  logic [4:0] pin_s;
  logic cs_s;
  logic sk_s;
  logic di_s;
  logic wide_s;
  logic guard_s;

  sep_sync #(.W(5)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({link.cs, link.sk, link.di, width_select_pin_i, write_guard_pin_i}),
    .q_o(pin_s)
  );
  assign {cs_s, sk_s, di_s, wide_s, guard_s} = pin_s;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Word at an address, left aligned
  function automatic logic [15:0] rword(input logic [10:0] a, input logic w);
    rword = w ? {mem[{a[9:0], 1'b0}], mem[{a[9:0], 1'b1}]} : {mem[a], 8'h00};
  endfunction : rword

  // Next address, wrapping at the top of the space
  function automatic logic [10:0] ainc(input logic [10:0] a, input logic w);
    ainc = w ? {1'b0, a[9:0] + 10'h001} : a + 11'h001;
  endfunction : ainc

  // Byte stored at an index during a walk
  function automatic logic [7:0] pbyte(input logic [15:0] d, input logic w, input logic odd);
    pbyte = (w && !odd) ? d[15:8] : d[7:0];
  endfunction : pbyte

  logic rise;
  logic fall;
  logic busy;
  logic [4:0] hlen;
  logic [4:0] wlen;
  logic [12:0] full;
  logic [1:0] f_op;
  logic [1:0] f_pfx;
  logic [10:0] f_addr;
  logic prog;
  logic [15:0] nw;

  assign rise = sk_s && !s.sk_q;
  assign fall = !sk_s && s.sk_q;
  assign busy = (s.tmr != '0) || s.walk;
  assign hlen = s.wide ? sep_pkg::HDR_X16 : sep_pkg::HDR_X8;
  assign wlen = s.wide ? sep_pkg::WLEN_X16 : sep_pkg::WLEN_X8;
  assign full = {s.hdr[11:0], di_s};
  assign f_op = s.wide ? full[11:10] : full[12:11];
  assign f_pfx = s.wide ? full[9:8] : full[10:9];
  assign f_addr = s.wide ? {1'b0, full[9:0]} : full[10:0];
  assign prog = (s.op != sep_pkg::OP_READ)
    && !(s.op == sep_pkg::OP_SPECIAL && (s.pfx == sep_pkg::PFX_LOCK
    || s.pfx == sep_pkg::PFX_UNLOCK));

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sk_q = sk_s;
    next_s.cs_q = cs_s;
    // Word after the current read address, follows memory contents
    nw = rword(ainc(s.addr, s.wide), s.wide);
    // self-timed cycle needs no serial clock
    if (s.tmr != '0) begin
      next_s.tmr = s.tmr - 1'b1;
    end
    if (s.walk) begin
      next_s.idx = s.idx + 11'h001;
      next_s.walk = s.idx != s.last;
    end
    if (!cs_s) begin
      next_s.st = S_IDLE;
      next_s.doe = 1'b0;
      next_s.rel = 1'b0;
      // dummy bit whose clock falls with select still ends status
      if (s.st == S_STAT && s.rel && fall) begin
        next_s.stat_on = 1'b0;
      end
      // guard pin and unlock gate it
      if (s.cs_q && s.st == S_DONE && prog && s.unlocked && guard_s && !busy) begin
        next_s.tmr = STORE_CYCLES[sep_pkg::TMR_W-1:0];
        next_s.stat_on = 1'b1;
        next_s.walk = 1'b1;
        next_s.wwide = s.wide;
        // write overwrites, so no prior clear is needed
        next_s.idx = s.wide ? {s.addr[9:0], 1'b0} : s.addr;
        next_s.last = s.wide ? {s.addr[9:0], 1'b1} : s.addr;
        // clear-all and fill-all walk every byte
        if (s.op == sep_pkg::OP_SPECIAL) begin
          next_s.idx = '0;
          next_s.last = 11'(sep_pkg::MEM_BYTES - 1);
        end
        if (s.op == sep_pkg::OP_ERASE
            || (s.op == sep_pkg::OP_SPECIAL && s.pfx == sep_pkg::PFX_CLEAR)) begin
          next_s.fdata = sep_pkg::ERASED;
        end
      end
    end else if (!s.cs_q) begin
      if (s.stat_on) begin
        next_s.st = S_STAT;
        next_s.doe = 1'b1;
        next_s.dout = !busy;
      end
    end else begin
      unique case (s.st)
        S_IDLE: begin
          // first high bit is the start bit
          if (rise && di_s) begin
            next_s.st = S_HDR;
            next_s.cnt = '0;
            next_s.hdr = '0;
            next_s.wide = wide_s;
          end
        end
        S_HDR: begin
          if (rise) begin
            next_s.hdr = full;
            next_s.cnt = s.cnt + 5'h01;
            if (s.cnt == hlen - 5'h01) begin
              next_s.op = f_op;
              next_s.pfx = f_pfx;
              next_s.addr = f_addr;
              next_s.cnt = '0;
              next_s.st = S_DONE;
              if (f_op == sep_pkg::OP_READ) begin
                // leave release, dummy low, load word
                next_s.st = S_READ;
                next_s.doe = 1'b1;
                next_s.dout = 1'b0;
                next_s.rd = rword(f_addr, s.wide);
                next_s.rcnt = '0;
              end else if (f_op == sep_pkg::OP_WRITE || (f_op == sep_pkg::OP_SPECIAL
                  && f_pfx == sep_pkg::PFX_FILL)) begin
                next_s.st = S_DATA;
              end else if (f_op == sep_pkg::OP_SPECIAL) begin
                // lock and unlock ignore the guard pin
                if (f_pfx == sep_pkg::PFX_UNLOCK) begin
                  next_s.unlocked = 1'b1;
                end else if (f_pfx == sep_pkg::PFX_LOCK) begin
                  next_s.unlocked = 1'b0;
                end
              end
            end
          end
        end
        S_DATA: begin
          if (rise) begin
            next_s.dsh = {s.dsh[14:0], di_s};
            next_s.cnt = s.cnt + 5'h01;
            if (s.cnt == wlen - 5'h01) begin
              next_s.st = S_DONE;
              next_s.fdata = s.wide ? {s.dsh[14:0], di_s} : {8'h00, s.dsh[6:0], di_s};
            end
          end
        end
        S_READ: begin
          if (rise) begin
            if (s.rcnt == wlen) begin
              next_s.addr = ainc(s.addr, s.wide);
              next_s.dout = nw[15];
              next_s.rd = {nw[14:0], 1'b0};
              next_s.rcnt = 5'h01;
            end else begin
              next_s.dout = s.rd[15];
              next_s.rd = {s.rd[14:0], 1'b0};
              next_s.rcnt = s.rcnt + 5'h01;
            end
          end
        end
        S_DONE: begin
          next_s.st = S_DONE;
        end
        S_STAT: begin
          next_s.dout = !busy;
          // dummy high bit, release on next fall
          if (rise && di_s) begin
            next_s.rel = 1'b1;
          end
          if (fall && s.rel) begin
            next_s.rel = 1'b0;
            next_s.doe = 1'b0;
            next_s.stat_on = 1'b0;
            next_s.st = S_IDLE;
          end
        end
      endcase
    end
  end

  // State register; reset leaves programming locked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Memory walk writes one byte per cycle
  always_ff @(posedge clk_i) begin
    if (s.walk) begin
      mem[s.idx] <= pbyte(s.fdata, s.wwide, s.idx[0]);
    end
  end

  // output driven only for read data and status
  assign link.dout = s.dout;
  assign link.doe = s.doe;
  assign busy_o = busy;
  assign unlocked_o = s.unlocked;
endmodule : sep_dev

// >>> verilog/sep_host.sv
// Serial bus master for the EEPROM command port, with Wishbone registers
`timescale 1ns/1ps
module sep_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial link
  sep_link_if.host link
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_GAP, H_POLL} sep_hst_e;

  typedef struct packed {
    sep_hst_e st;
    logic cs;
    logic sk;
    logic di;
    logic [28:0] tx;
    logic [5:0] nbit;
    logic [4:0] tmr;
    logic [15:0] rx;
    logic [2:0] cmd;
    logic wide;
    logic [10:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic poll;
    logic ack;
    logic [31:0] dat;
  } sep_host_s;

  sep_host_s s;
  sep_host_s next_s;
  logic do_s;
  localparam logic [4:0] HALF = 5'(sep_pkg::HALF_CYC - 1);
  localparam logic [4:0] GAP = 5'(sep_pkg::GAP_CYC - 1);

  sep_sync #(.W(1)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(link.do_line),
    .q_o(do_s)
  );

  // Opcode and address prefix of a command
  function automatic logic [3:0] cmd_code(input logic [2:0] c);
    unique case (c)
      sep_pkg::CMD_READ: cmd_code = {sep_pkg::OP_READ, 2'h0};
      sep_pkg::CMD_WRITE: cmd_code = {sep_pkg::OP_WRITE, 2'h0};
      sep_pkg::CMD_ERASE: cmd_code = {sep_pkg::OP_ERASE, 2'h0};
      sep_pkg::CMD_UNLOCK: cmd_code = {sep_pkg::OP_SPECIAL, sep_pkg::PFX_UNLOCK};
      sep_pkg::CMD_LOCK: cmd_code = {sep_pkg::OP_SPECIAL, sep_pkg::PFX_LOCK};
      sep_pkg::CMD_CLEAR: cmd_code = {sep_pkg::OP_SPECIAL, sep_pkg::PFX_CLEAR};
      default: cmd_code = {sep_pkg::OP_SPECIAL, sep_pkg::PFX_FILL};
    endcase
  endfunction : cmd_code

  logic req;
  logic [3:0] code;
  logic [10:0] a;
  logic has_data;
  logic is_prog;
  logic [4:0] wlen;
  logic [15:0] rxn;

  assign req = wb_cyc_i && wb_stb_i && !s.ack;
  assign code = cmd_code(s.cmd);
  assign a = (code[3:2] != sep_pkg::OP_SPECIAL) ? s.addr
    : (s.wide ? {1'b0, code[1:0], 8'h00} : {code[1:0], 9'h000});
  assign has_data = s.cmd == sep_pkg::CMD_WRITE || s.cmd == sep_pkg::CMD_FILL;
  assign is_prog = has_data || s.cmd == sep_pkg::CMD_ERASE || s.cmd == sep_pkg::CMD_CLEAR;
  assign wlen = s.wide ? sep_pkg::WLEN_X16 : sep_pkg::WLEN_X8;
  assign rxn = {s.rx[14:0], do_s};

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ack = req;
    if (s.tmr != '0) begin
      next_s.tmr = s.tmr - 5'h01;
    end
    // Register access, answered one cycle after the request
    if (req && wb_we_i && wb_sel_i[0] && s.st == H_IDLE) begin
      if (wb_adr_i == sep_pkg::REG_CTRL) begin
        next_s.cmd = wb_dat_i[2:0];
        next_s.wide = wb_dat_i[sep_pkg::CTRL_WIDE_BIT];
        next_s.done = 1'b0;
        next_s.poll = 1'b0;
        next_s.cs = 1'b1;
        next_s.tmr = HALF;
        next_s.st = H_SETUP;
      end else if (wb_adr_i == sep_pkg::REG_ADDR) begin
        next_s.addr = {wb_sel_i[1] ? wb_dat_i[10:8] : s.addr[10:8], wb_dat_i[7:0]};
      end else if (wb_adr_i == sep_pkg::REG_WDATA) begin
        next_s.wdata = {wb_sel_i[1] ? wb_dat_i[15:8] : s.wdata[15:8], wb_dat_i[7:0]};
      end
    end
    unique case (wb_adr_i)
      sep_pkg::REG_CTRL: next_s.dat = {28'h0000000, s.wide, s.cmd};
      sep_pkg::REG_ADDR: next_s.dat = {21'h000000, s.addr};
      sep_pkg::REG_WDATA: next_s.dat = {16'h0000, s.wdata};
      sep_pkg::REG_RDATA: next_s.dat = {16'h0000, s.rdata};
      sep_pkg::REG_STAT: next_s.dat = {30'h00000000, s.done, s.st != H_IDLE};
      default: next_s.dat = '0;
    endcase
    unique case (s.st)
      H_IDLE: begin
        next_s.cs = 1'b0;
      end
      H_SETUP: begin
        // Raise select, build the frame while it settles
        next_s.cs = 1'b1;
        next_s.tx = s.wide ? {1'b1, code[3:2], a[9:0], s.wdata}
          : {1'b1, code[3:2], a, s.wdata[7:0], 7'h00};
        next_s.nbit = {1'b0, s.wide ? sep_pkg::HDR_X16 : sep_pkg::HDR_X8} + 6'h01
          + (has_data ? {1'b0, wlen} : 6'h00)
          + (s.cmd == sep_pkg::CMD_READ ? {1'b0, wlen} : 6'h00);
        if (s.tmr == '0) begin
          next_s.st = H_LOW;
          next_s.di = 1'b1;
          next_s.tmr = HALF;
        end
      end
      H_LOW: begin
        if (s.tmr == '0) begin
          next_s.sk = 1'b1;
          next_s.tmr = HALF;
          next_s.st = H_HIGH;
        end
      end
      H_HIGH: begin
        // Sample the reply, then lower the clock and present the next bit
        if (s.tmr == '0) begin
          next_s.sk = 1'b0;
          next_s.rx = rxn;
          next_s.tx = {s.tx[27:0], 1'b0};
          next_s.di = s.tx[27];
          next_s.nbit = s.nbit - 6'h01;
          next_s.tmr = HALF;
          next_s.st = H_LOW;
          if (s.nbit == 6'h01) begin
            next_s.cs = 1'b0;
            next_s.di = 1'b0;
            next_s.tmr = GAP;
            next_s.st = H_GAP;
            if (s.cmd == sep_pkg::CMD_READ && !s.poll) begin
              next_s.rdata = s.wide ? rxn : {8'h00, rxn[7:0]};
            end
          end
        end
      end
      H_GAP: begin
        // Select stays low for the least gap
        if (s.tmr == '0) begin
          if (is_prog && !s.poll) begin
            next_s.cs = 1'b1;
            next_s.poll = 1'b1;
            next_s.tmr = HALF;
            next_s.st = H_POLL;
          end else begin
            next_s.done = 1'b1;
            next_s.st = H_IDLE;
          end
        end
      end
      H_POLL: begin
        // Wait for ready, then clock one high bit to release the line
        if (s.tmr == '0 && do_s) begin
          next_s.tx = '0;
          next_s.di = 1'b1;
          next_s.nbit = 6'h01;
          next_s.tmr = HALF;
          next_s.st = H_LOW;
        end
      end
      default: begin
        next_s.st = H_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign link.cs = s.cs;
  assign link.sk = s.sk;
  assign link.di = s.di;
endmodule : sep_host

// >>> sim/sep_link_monitor.sv
// Concurrent checks on the serial link and the command port status
`timescale 1ns/1ps
module sep_link_monitor #(
  parameter int unsigned STORE_CYCLES = 300
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  input wire logic dout,
  input wire logic doe,
  // Device status
  input wire logic busy_o,
  input wire logic unlocked_o
);
  int unsigned busy_cnt;

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Length of the running store, zero while idle
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  // ----------------------------------------------------------
  // Sequences and assertions
  // ----------------------------------------------------------
  sequence gap_low;
    !cs [*8];
  endsequence
  sequence sk_steady;
    $stable(sk) [*8];
  endsequence

  sel_release_a: assert property (!cs [*5] |-> !doe)
    else $error("output driven while deselected");
  doe_needs_sel_a: assert property ($rose(doe) |-> $past(cs, 2))
    else $error("output enabled without select");
  busy_status_a: assert property (busy_o && doe |-> !dout)
    else $error("status high during store");
  store_start_a: assert property ($rose(busy_o) |-> !cs && !$past(cs, 2))
    else $error("store began while selected");
  store_len_a: assert property ($fell(busy_o) |->
    busy_cnt >= STORE_CYCLES - 1 && busy_cnt <= STORE_CYCLES + 1)
    else $error("store length wrong");
  store_unlock_a: assert property ($rose(busy_o) |-> unlocked_o)
    else $error("store began while locked");
  select_gap_a: assert property ($fell(cs) |-> gap_low)
    else $error("select low gap too short");
  clock_half_a: assert property ($changed(sk) |=> sk_steady)
    else $error("serial clock half period too short");
  input_setup_a: assert property ($rose(sk) |-> $stable(di))
    else $error("serial input moved at clock rise");
endmodule : sep_link_monitor

// >>> sim/tb.sv
// Testbench joining controller and command port over the serial link
`timescale 1ns/1ps
module tb;
  logic clk_i;
  logic rst_i;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic wide;
  logic guard;
  logic busy;
  logic unlocked;
  logic [31:0] q;
  int n_errors;
  int n_checks;
  int cycles;

  sep_link_if link ();
  // Store time must outlast the full-memory byte walk of 2048 cycles
  sep_dev #(.STORE_CYCLES(3000)) sep_dev_i (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .width_select_pin_i(wide), .write_guard_pin_i(guard), .busy_o(busy),
    .unlocked_o(unlocked));
  sep_host sep_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link(link));
  sep_link_monitor #(.STORE_CYCLES(3000)) sep_link_monitor_i (.clk_i(clk_i),
    .rst_i(rst_i), .cs(link.cs), .sk(link.sk), .di(link.di), .dout(link.dout),
    .doe(link.doe), .busy_o(busy), .unlocked_o(unlocked));

  // Clock at 40 MHz
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      end_sim();
    end
  end

  task end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // One classic Wishbone cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only ack or the bench timeout ends this wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb

  // Starts a command, waits for done, leaves read data in q
  task run(input logic [2:0] c, input logic [10:0] a, input logic [15:0] d);
    int n;
    n = 0;
    wb(1'h1, sep_pkg::REG_ADDR, {21'h0, a});
    wb(1'h1, sep_pkg::REG_WDATA, {16'h0, d});
    wb(1'h1, sep_pkg::REG_CTRL, {28'h0, wide, c});
    do begin
      wb(1'h0, sep_pkg::REG_STAT, 32'h0);
      n++;
    end while (q[1:0] !== 2'h2 && n < 4000);
    if (n == 4000) begin
      n_errors++;
      $display("wrong value at %0t: command never finished", $time);
    end
    wb(1'h0, sep_pkg::REG_RDATA, 32'h0);
  endtask : run

  task rd_chk(input logic [10:0] a, input logic [15:0] exp);
    run(sep_pkg::CMD_READ, a, 16'h0);
    check(q, {16'h0, exp}, "read word");
  endtask : rd_chk

  task t_unlock_clear;
    check({31'h0, unlocked}, 32'h0, "locked at reset");
    run(sep_pkg::CMD_UNLOCK, 11'h0, 16'h0);
    check({31'h0, unlocked}, 32'h1, "unlocked");
    run(sep_pkg::CMD_CLEAR, 11'h0, 16'h0);
    rd_chk(11'h3, sep_pkg::ERASED);
    rd_chk(11'h3FF, sep_pkg::ERASED);
    $display("test unlock_clear done");
  endtask : t_unlock_clear

  task t_lock;
    run(sep_pkg::CMD_LOCK, 11'h0, 16'h0);
    check({31'h0, unlocked}, 32'h0, "locked");
    run(sep_pkg::CMD_WRITE, 11'h3, 16'h1234);
    rd_chk(11'h3, sep_pkg::ERASED);
    $display("test lock done");
  endtask : t_lock

  task t_write_erase;
    run(sep_pkg::CMD_UNLOCK, 11'h0, 16'h0);
    run(sep_pkg::CMD_WRITE, 11'h3, 16'hA5C3);
    rd_chk(11'h3, 16'hA5C3);
    rd_chk(11'h4, sep_pkg::ERASED);
    run(sep_pkg::CMD_WRITE, 11'h3, 16'h0F0F);
    rd_chk(11'h3, 16'h0F0F);
    run(sep_pkg::CMD_ERASE, 11'h3, 16'h0);
    rd_chk(11'h3, sep_pkg::ERASED);
    $display("test write_erase done");
  endtask : t_write_erase

  task t_fill_guard;
    run(sep_pkg::CMD_FILL, 11'h0, 16'h5A69);
    rd_chk(11'h0, 16'h5A69);
    rd_chk(11'h3FF, 16'h5A69);
    guard <= 1'h0;
    run(sep_pkg::CMD_WRITE, 11'h7, 16'h0000);
    rd_chk(11'h7, 16'h5A69);
    run(sep_pkg::CMD_LOCK, 11'h0, 16'h0);
    check({31'h0, unlocked}, 32'h0, "lock ignores guard");
    run(sep_pkg::CMD_UNLOCK, 11'h0, 16'h0);
    check({31'h0, unlocked}, 32'h1, "unlock ignores guard");
    guard <= 1'h1;
    $display("test fill_guard done");
  endtask : t_fill_guard

  task t_narrow;
    wide <= 1'h0;
    rd_chk(11'h7FE, 16'h005A);
    run(sep_pkg::CMD_WRITE, 11'h7FF, 16'h003C);
    rd_chk(11'h7FF, 16'h003C);
    wide <= 1'h1;
    rd_chk(11'h3FF, 16'h5A3C);
    wb(1'h0, 8'h20, 32'h0);
    check(q, 32'h0, "unmapped read");
    $display("test narrow done");
  endtask : t_narrow

  // Reset, then the scenarios in order
  initial begin
    rst_i = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    wdat = 32'h0;
    wide = 1'h1;
    guard = 1'h1;
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    t_unlock_clear();
    t_lock();
    t_write_erase();
    t_fill_guard();
    t_narrow();
    end_sim();
  end
endmodule : tb
